// File: hdl/dmr_pkg.sv
// dmr_pkg: field positions, reset values and encodings for the mode register pair.
// assumes a single clock domain and a bank/row address presented with the command.
package dmr_pkg;
  localparam int DMR_REG_W = 19;
  localparam int DMR_BA_W = 3;
  localparam logic [2:0] DMR_BA_MODE_ONE = 3'h1;
  localparam logic [2:0] DMR_BA_MODE_TWO = 3'h2;
  // mode register one fields
  localparam int DMR_M1_DLL_OFF = 0;
  localparam int DMR_M1_DRV_LO = 1;
  localparam int DMR_M1_RTT_LO = 2;
  localparam int DMR_M1_AL_LO = 3;
  localparam int DMR_M1_AL_HI = 4;
  localparam int DMR_M1_DRV_HI = 5;
  localparam int DMR_M1_RTT_MID = 6;
  localparam int DMR_M1_WLEV = 7;
  localparam int DMR_M1_RTT_HI = 9;
  localparam int DMR_M1_TDQS = 11;
  localparam int DMR_M1_QOFF = 12;
  // mode register two fields
  localparam int DMR_M2_CWL_LO = 3;
  localparam int DMR_M2_CWL_HI = 5;
  localparam int DMR_M2_ASR = 6;
  localparam int DMR_M2_SRT = 7;
  localparam int DMR_M2_RWR_LO = 9;
  localparam int DMR_M2_RWR_HI = 10;
  // reset values: dll on, drive rzq/7, everything else off
  localparam logic [18:0] DMR_M1_RESET = 19'h00002;
  localparam logic [18:0] DMR_M2_RESET = 19'h00000;
  // termination codes {bit9,bit6,bit2}
  localparam logic [2:0] DMR_RTT_OFF = 3'h0;
  localparam logic [2:0] DMR_RTT_DIV4 = 3'h1;
  localparam logic [2:0] DMR_RTT_DIV2 = 3'h2;
  localparam logic [2:0] DMR_RTT_DIV6 = 3'h3;
  localparam logic [2:0] DMR_RTT_DIV12 = 3'h4;
  localparam logic [2:0] DMR_RTT_DIV8 = 3'h5;
  localparam logic [1:0] DMR_DRV_RZQ7 = 2'h1;
  localparam logic [1:0] DMR_DRV_RZQ6 = 2'h0;
  typedef enum logic [1:0] {DMR_AL_ZERO, DMR_AL_CL1, DMR_AL_CL2, DMR_AL_RSVD} dmr_al_t;
endpackage

// File: hdl/dmr_rtt_sel.sv
// dmr_rtt_sel: picks the active termination code for the data balls.
// assumes registered mode fields and synchronous odt/write/read qualifiers.
module dmr_rtt_sel
  import dmr_pkg::*;
(
  input wire logic [2:0] rtt_nom,
  input wire logic [1:0] rtt_wr,
  input wire logic odt_pin,
  input wire logic write_burst,
  input wire logic read_burst,
  input wire logic wlev_on,
  input wire logic dll_on,
  input wire logic self_refresh,
  output logic [2:0] rtt_code,
  output logic rtt_wr_used
);
  // rtt_wr code 1=div4, 2=div2
  function automatic logic [2:0] wr_to_code(input logic [1:0] w);
    case (w)
      2'h1: wr_to_code = DMR_RTT_DIV4;
      2'h2: wr_to_code = DMR_RTT_DIV2;
      default: wr_to_code = DMR_RTT_OFF;
    endcase
  endfunction

  always_comb begin
    rtt_code = DMR_RTT_OFF;
    rtt_wr_used = 1'b0;
    // no termination while reading, in self refresh or with dll off
    if (odt_pin && !read_burst && !self_refresh && dll_on) begin
      if (write_burst && !wlev_on && rtt_wr != 2'h0) begin
        rtt_code = wr_to_code(rtt_wr);
        rtt_wr_used = 1'b1;
      end else begin
        rtt_code = rtt_nom;
      end
    end
  end
endmodule // dmr_rtt_sel

// File: hdl/dmr_mode_regs.sv
// dmr_mode_regs: holds mode registers one and two and decodes their fields.
// assumes mrs commands arrive decoded and synchronous to the device clock.
//
// Contract
// - mode register one holds its value until rewritten or reset.
// - mode register writes never touch the memory array.
// - write leveling allows all termination if outputs off, else write values only.
// - bit 0 selects dll enable; controller keeps it enabled normally.
// - enabled dll goes off in self refresh, re-enables and resets on exit.
// - disabled dll stays disabled after self refresh exit.
// - bits 5 and 1 select drive impedance; rzq/7 is the primary setting.
// - bit 12 set tristates data and strobe outputs.
// - bit 11 moves termination to tdqs and disables data mask on x8.
// - bits 9, 6, 2 select nominal termination rzq/2..rzq/12.
// - writes with dynamic termination use the write value instead.
// - odt pin gates nominal termination on and off.
// - bit 7 enables write leveling mode.
// - bits 4 and 3 set additive latency zero, cl-1 or cl-2.
// - register two written when idle and held until rewritten; reset here still clears it to zero.
// - register two holds write latency, asr, srt and dynamic termination.
module dmr_mode_regs
  import dmr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic mrs_cmd,
  input wire logic [2:0] bank_addr,
  input wire logic [15:0] row_addr,
  input wire logic odt_pin,
  input wire logic write_burst,
  input wire logic read_burst,
  input wire logic self_refresh,
  input wire logic x8_part,
  output logic dll_on,
  output logic dll_reset_pulse,
  output logic [1:0] drive_sel,
  output logic [1:0] additive_lat,
  output logic wlev_on,
  output logic outputs_off,
  output logic tdqs_on,
  output logic dm_on,
  output logic [2:0] rtt_code,
  output logic rtt_wr_used,
  output logic wlev_rtt_bad,
  output logic [2:0] cas_write_lat,
  output logic asr_on,
  output logic srt_on,
  output logic [1:0] rtt_wr_sel,
  output logic [18:0] mode_one_q,
  output logic [18:0] mode_two_q
);
  logic [18:0] mode_one_d;
  logic [18:0] mode_two_d;
  logic sr_q;
  logic dll_parked_q;
  logic [2:0] rtt_nom_w;
  logic [2:0] rtt_code_d;
  logic rtt_wr_used_d;
  logic wlev_bad_d;

  // bits 18:16 have no address line here and always store zero
  function automatic logic [18:0] mrs_image(input logic [15:0] a);
    mrs_image = {3'h0, a};
  endfunction

  function automatic logic is_write_rtt(input logic [2:0] c);
    is_write_rtt = (c == DMR_RTT_OFF) || (c == DMR_RTT_DIV4) || (c == DMR_RTT_DIV2) ||
      (c == DMR_RTT_DIV6);
  endfunction

  // array contents are not reachable from here, so mode writes cannot disturb them
  always_comb begin
    mode_one_d = mode_one_q;
    if (mrs_cmd && bank_addr == DMR_BA_MODE_ONE) begin
      mode_one_d = mrs_image(row_addr);
    end
  end

  always_comb begin
    mode_two_d = mode_two_q;
    if (mrs_cmd && bank_addr == DMR_BA_MODE_TWO) begin
      mode_two_d = mrs_image(row_addr);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_one_q <= DMR_M1_RESET;
    end else begin
      mode_one_q <= mode_one_d;
    end
  end

  // register two only loses its value with power; reset still gives a defined start
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_two_q <= DMR_M2_RESET;
    end else begin
      mode_two_q <= mode_two_d;
    end
  end

  // self refresh tracking for the dll
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sr_q <= 1'b0;
    end else begin
      sr_q <= self_refresh;
    end
  end

  // remembers whether the dll was running at entry, so exit knows whether to pulse the dll reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dll_parked_q <= 1'b0;
    end else if (self_refresh && !sr_q) begin
      dll_parked_q <= !mode_one_q[DMR_M1_DLL_OFF];
    end else if (!self_refresh && sr_q) begin
      dll_parked_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dll_on <= 1'b1;
      dll_reset_pulse <= 1'b0;
    end else begin
      // bit 0 low means dll enabled; self refresh parks it
      dll_on <= !mode_one_d[DMR_M1_DLL_OFF] && !self_refresh;
      dll_reset_pulse <= !self_refresh && sr_q && dll_parked_q;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      drive_sel <= DMR_DRV_RZQ7;
      additive_lat <= 2'h0;
      wlev_on <= 1'b0;
      outputs_off <= 1'b0;
      tdqs_on <= 1'b0;
      dm_on <= 1'b1;
    end else begin
      drive_sel <= {mode_one_d[DMR_M1_DRV_HI], mode_one_d[DMR_M1_DRV_LO]};
      additive_lat <= {mode_one_d[DMR_M1_AL_HI], mode_one_d[DMR_M1_AL_LO]};
      wlev_on <= mode_one_d[DMR_M1_WLEV];
      outputs_off <= mode_one_d[DMR_M1_QOFF];
      // tdqs only exists on the x8 part; wider or narrower parts keep data mask
      tdqs_on <= mode_one_d[DMR_M1_TDQS] && x8_part;
      dm_on <= !(mode_one_d[DMR_M1_TDQS] && x8_part);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cas_write_lat <= 3'h0;
      asr_on <= 1'b0;
      srt_on <= 1'b0;
      rtt_wr_sel <= 2'h0;
    end else begin
      cas_write_lat <= mode_two_d[DMR_M2_CWL_HI:DMR_M2_CWL_LO];
      asr_on <= mode_two_d[DMR_M2_ASR];
      srt_on <= mode_two_d[DMR_M2_SRT];
      rtt_wr_sel <= mode_two_d[DMR_M2_RWR_HI:DMR_M2_RWR_LO];
    end
  end

  assign rtt_nom_w = {mode_one_q[DMR_M1_RTT_HI], mode_one_q[DMR_M1_RTT_MID],
    mode_one_q[DMR_M1_RTT_LO]};

  dmr_rtt_sel u_rtt_sel (
    .rtt_nom(rtt_nom_w),
    .rtt_wr(mode_two_q[DMR_M2_RWR_HI:DMR_M2_RWR_LO]),
    .odt_pin(odt_pin),
    .write_burst(write_burst),
    .read_burst(read_burst),
    .wlev_on(mode_one_q[DMR_M1_WLEV]),
    .dll_on(!mode_one_q[DMR_M1_DLL_OFF]),
    .self_refresh(self_refresh),
    .rtt_code(rtt_code_d),
    .rtt_wr_used(rtt_wr_used_d)
  );

  // during leveling with outputs enabled, only write-capable codes may be used
  always_comb begin
    wlev_bad_d = mode_one_q[DMR_M1_WLEV] && !mode_one_q[DMR_M1_QOFF] &&
      !is_write_rtt(rtt_nom_w);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rtt_code <= DMR_RTT_OFF;
      rtt_wr_used <= 1'b0;
      wlev_rtt_bad <= 1'b0;
    end else begin
      // blocked code falls back to off rather than an illegal value
      rtt_code <= wlev_bad_d ? DMR_RTT_OFF : rtt_code_d;
      rtt_wr_used <= rtt_wr_used_d;
      wlev_rtt_bad <= wlev_bad_d;
    end
  end

  AST_LOAD_ONE: assert property (@(posedge clock) disable iff (!reset_n)
    mrs_cmd && bank_addr == DMR_BA_MODE_ONE |=> mode_one_q == $past(mrs_image(row_addr)))
    else $error("mode one not loaded");
  AST_LOAD_TWO: assert property (@(posedge clock) disable iff (!reset_n)
    mrs_cmd && bank_addr == DMR_BA_MODE_TWO |=> mode_two_q == $past(mrs_image(row_addr)))
    else $error("mode two not loaded");
  AST_HOLD_ONE: assert property (@(posedge clock) disable iff (!reset_n)
    !(mrs_cmd && bank_addr == DMR_BA_MODE_ONE) |=> $stable(mode_one_q))
    else $error("mode one changed without write");
  AST_QOFF: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 outputs_off == mode_one_q[DMR_M1_QOFF])
    else $error("output disable mismatch");
  AST_TDQS_DM: assert property (@(posedge clock) disable iff (!reset_n)
    tdqs_on != dm_on)
    else $error("tdqs and dm both active");
  AST_SR_DLL: assert property (@(posedge clock) disable iff (!reset_n)
    self_refresh |=> !dll_on)
    else $error("dll on in self refresh");
  // exit with the dll bit still off: no restart and no reset pulse
  sequence sr_exit_off_s;
    self_refresh ##1 (!self_refresh && mode_one_q[DMR_M1_DLL_OFF] && !mrs_cmd);
  endsequence
  AST_SR_EXIT: assert property (@(posedge clock) disable iff (!reset_n)
    sr_exit_off_s |=> !dll_on && !dll_reset_pulse)
    else $error("disabled dll came back after self refresh");
  AST_RTT_READ: assert property (@(posedge clock) disable iff (!reset_n)
    !odt_pin || read_burst |=> rtt_code == DMR_RTT_OFF)
    else $error("termination on without odt");
  AST_AL: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 additive_lat == {mode_one_q[DMR_M1_AL_HI], mode_one_q[DMR_M1_AL_LO]})
    else $error("additive latency mismatch");

  // register two hold, foreign banks and field decode
  AST_HOLD_TWO: assert property (@(posedge clock) disable iff (!reset_n)
    !(mrs_cmd && bank_addr == DMR_BA_MODE_TWO) |=> $stable(mode_two_q))
    else $error("mode two changed without write");
  AST_OTHER_BANK: assert property (@(posedge clock) disable iff (!reset_n)
    mrs_cmd && bank_addr != DMR_BA_MODE_ONE && bank_addr != DMR_BA_MODE_TWO
    |=> $stable(mode_one_q) && $stable(mode_two_q))
    else $error("foreign bank touched a mode register");
  AST_CWL: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 cas_write_lat == mode_two_q[DMR_M2_CWL_HI:DMR_M2_CWL_LO])
    else $error("write latency mismatch");
  AST_ASR: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 asr_on == mode_two_q[DMR_M2_ASR])
    else $error("auto self refresh mismatch");
  AST_SRT: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 srt_on == mode_two_q[DMR_M2_SRT])
    else $error("self refresh temperature mismatch");
  AST_RWR: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 rtt_wr_sel == mode_two_q[DMR_M2_RWR_HI:DMR_M2_RWR_LO])
    else $error("write termination field mismatch");

  // register one field decode
  AST_DRV: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 drive_sel == {mode_one_q[DMR_M1_DRV_HI], mode_one_q[DMR_M1_DRV_LO]})
    else $error("drive strength mismatch");
  AST_WLEV: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 wlev_on == mode_one_q[DMR_M1_WLEV])
    else $error("write leveling mismatch");
  AST_TDQS_X8: assert property (@(posedge clock) disable iff (!reset_n)
    x8_part |=> tdqs_on == mode_one_q[DMR_M1_TDQS] && dm_on == !mode_one_q[DMR_M1_TDQS])
    else $error("tdqs select wrong on x8");
  AST_TDQS_X4: assert property (@(posedge clock) disable iff (!reset_n)
    !x8_part |=> !tdqs_on && dm_on)
    else $error("tdqs active on a part without it");

  // dll across self refresh entry and exit
  AST_DLL_BIT: assert property (@(posedge clock) disable iff (!reset_n)
    !self_refresh |=> dll_on == !mode_one_q[DMR_M1_DLL_OFF])
    else $error("dll state does not follow bit 0");
  sequence sr_entry_s;
    !self_refresh ##1 self_refresh;
  endsequence
  AST_PARK_ENTRY: assert property (@(posedge clock) disable iff (!reset_n)
    sr_entry_s |=> dll_parked_q == !$past(mode_one_q[DMR_M1_DLL_OFF]))
    else $error("dll state at entry not remembered");
  sequence sr_exit_on_s;
    self_refresh ##1 (!self_refresh && dll_parked_q && !mode_one_q[DMR_M1_DLL_OFF] &&
      !mrs_cmd);
  endsequence
  AST_SR_EXIT_ON: assert property (@(posedge clock) disable iff (!reset_n)
    sr_exit_on_s |=> dll_on && dll_reset_pulse)
    else $error("dll not restarted after self refresh");
  AST_PULSE_ONE: assert property (@(posedge clock) disable iff (!reset_n)
    dll_reset_pulse |=> !dll_reset_pulse)
    else $error("dll reset pulse too long");
  AST_PULSE_EXIT: assert property (@(posedge clock) disable iff (!reset_n)
    !(sr_q && !self_refresh) |=> !dll_reset_pulse)
    else $error("dll reset pulse outside self refresh exit");

  // termination selection; a stale code on the balls is the hazard here
  AST_RTT_SR: assert property (@(posedge clock) disable iff (!reset_n)
    self_refresh |=> rtt_code == DMR_RTT_OFF)
    else $error("termination on in self refresh");
  AST_RTT_DLL_OFF: assert property (@(posedge clock) disable iff (!reset_n)
    mode_one_q[DMR_M1_DLL_OFF] |=> rtt_code == DMR_RTT_OFF)
    else $error("termination on with dll off");
  AST_NOM_RTT: assert property (@(posedge clock) disable iff (!reset_n)
    odt_pin && !write_burst && !read_burst && !self_refresh &&
    !mode_one_q[DMR_M1_DLL_OFF] && !mode_one_q[DMR_M1_WLEV] |=> rtt_code == $past(rtt_nom_w))
    else $error("nominal termination not applied");
  AST_RTT_WR: assert property (@(posedge clock) disable iff (!reset_n)
    odt_pin && write_burst && !read_burst && !self_refresh &&
    !mode_one_q[DMR_M1_DLL_OFF] && !mode_one_q[DMR_M1_WLEV] &&
    mode_two_q[DMR_M2_RWR_HI:DMR_M2_RWR_LO] != 2'h0 |=> rtt_wr_used)
    else $error("write termination not applied");
  AST_WR_NOT_LEVEL: assert property (@(posedge clock) disable iff (!reset_n)
    mode_one_q[DMR_M1_WLEV] || !odt_pin || read_burst |=> !rtt_wr_used)
    else $error("write termination used when not allowed");

  // leveling with outputs enabled must never show a code that writes cannot use
  AST_WLEV_CODE: assert property (@(posedge clock) disable iff (!reset_n)
    mode_one_q[DMR_M1_WLEV] && !mode_one_q[DMR_M1_QOFF] |=> rtt_code == DMR_RTT_OFF ||
    rtt_code == DMR_RTT_DIV4 || rtt_code == DMR_RTT_DIV2 || rtt_code == DMR_RTT_DIV6)
    else $error("non write termination during leveling");
  AST_WLEV_BLOCK: assert property (@(posedge clock) disable iff (!reset_n)
    mode_one_q[DMR_M1_WLEV] && !mode_one_q[DMR_M1_QOFF] &&
    (rtt_nom_w == DMR_RTT_DIV12 || rtt_nom_w == DMR_RTT_DIV8) |=> wlev_rtt_bad)
    else $error("illegal leveling code not flagged");
  AST_WLEV_QOFF: assert property (@(posedge clock) disable iff (!reset_n)
    mode_one_q[DMR_M1_WLEV] && mode_one_q[DMR_M1_QOFF] |=> !wlev_rtt_bad)
    else $error("leveling code flagged with outputs off");
endmodule // dmr_mode_regs

// File: tb/dmr_ctrl_model.sv
// dmr_ctrl_model: memory controller side, issues mode register set commands.
// assumes the bench calls mrs only while no burst runs and after reset release.
module dmr_ctrl_model
  import dmr_pkg::*;
(
  input wire logic clock,
  input wire logic x8_part,
  output logic mrs_cmd,
  output logic [2:0] bank_addr,
  output logic [15:0] row_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    mrs_cmd = 1'b0;
    bank_addr = 3'h0;
    row_addr = 16'h0000;
  end
  // reserved bits are masked here so no scenario breaks them by accident
  task automatic mrs(input logic [2:0] ba, input logic [15:0] ra);
    logic [15:0] m;
    m = 16'hffff;
    if (ba == DMR_BA_MODE_ONE) m = x8_part ? 16'h1aff : 16'h12ff;
    if (ba == DMR_BA_MODE_TWO) m = ra[6] ? 16'h0678 : 16'h06f8;
    @(negedge clock);
    mrs_cmd = 1'b1;
    bank_addr = ba;
    row_addr = ra & m;
    @(negedge clock);
    mrs_cmd = 1'b0;
    // address lines are driven to the complement of ba and the unmasked ra once the command is gone
    bank_addr = ~ba;
    row_addr = ~ra;
    // every mode one mrs with bit 0 low (dll enabled) is chased by a dll reset in register zero
    if (ba == DMR_BA_MODE_ONE && !ra[DMR_M1_DLL_OFF]) begin
      @(negedge clock);
      mrs_cmd = 1'b1;
      bank_addr = 3'h0;
      row_addr = 16'h0100;
      @(negedge clock);
      mrs_cmd = 1'b0;
      bank_addr = 3'h7;
      row_addr = 16'hfeff;
    end
  endtask
endmodule // dmr_ctrl_model

// File: tb/dmr_mode_regs_tb.sv
// dmr_mode_regs_tb: directed checks of the mode register pair through mrs calls.
// assumes dmr_ctrl_model drives the command bus; bench drives the level inputs.
module dmr_mode_regs_tb import dmr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset_n, mrs_cmd, odt_pin, write_burst, read_burst, self_refresh, x8_part;
  logic [2:0] bank_addr, rtt_code, cas_write_lat;
  logic [15:0] row_addr;
  logic dll_on, dll_reset_pulse, wlev_on, outputs_off, tdqs_on, dm_on;
  logic rtt_wr_used, wlev_rtt_bad, asr_on, srt_on, pulse;
  logic [1:0] drive_sel, additive_lat, rtt_wr_sel;
  logic [18:0] mode_one_q, mode_two_q, last;
  int error_cnt = 0;
  int tests_run = 0;
  dmr_mode_regs dut (.clock(clock), .reset_n(reset_n), .mrs_cmd(mrs_cmd),
    .bank_addr(bank_addr), .row_addr(row_addr), .odt_pin(odt_pin),
    .write_burst(write_burst), .read_burst(read_burst), .self_refresh(self_refresh),
    .x8_part(x8_part), .dll_on(dll_on), .dll_reset_pulse(dll_reset_pulse),
    .drive_sel(drive_sel), .additive_lat(additive_lat), .wlev_on(wlev_on),
    .outputs_off(outputs_off), .tdqs_on(tdqs_on), .dm_on(dm_on), .rtt_code(rtt_code),
    .rtt_wr_used(rtt_wr_used), .wlev_rtt_bad(wlev_rtt_bad), .cas_write_lat(cas_write_lat),
    .asr_on(asr_on), .srt_on(srt_on), .rtt_wr_sel(rtt_wr_sel), .mode_one_q(mode_one_q),
    .mode_two_q(mode_two_q));
  dmr_ctrl_model ctrl (.clock(clock), .x8_part(x8_part), .mrs_cmd(mrs_cmd),
    .bank_addr(bank_addr), .row_addr(row_addr));
  always #25 clock = ~clock;
  function automatic logic [15:0] m1(logic off, logic [1:0] drv, logic [1:0] al,
    logic [2:0] rtt, logic wl, logic td, logic qo);
    m1 = {3'h0, qo, td, 1'b0, rtt[2], 1'b0, wl, rtt[1], drv[1], al, rtt[0], drv[0], off};
  endfunction
  task automatic chk(input string n, input logic [18:0] seen, input logic [18:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (2) @(negedge clock);
  endtask
  // self refresh entry and exit, then a short window for the dll reset pulse
  task automatic sr_cycle();
    self_refresh = 1'b1;
    settle();
    chk("dll_in_sr", dll_on, 0);
    self_refresh = 1'b0;
    pulse = 1'b0;
    repeat (4) begin
      @(negedge clock);
      pulse = pulse | dll_reset_pulse;
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clock);
    error_cnt++;
    summarize();
  end
  initial begin
    reset_n = 0;
    {odt_pin, write_burst, read_burst, self_refresh} = 4'h0;
    x8_part = 1;
    repeat (5) @(negedge clock);
    reset_n = 1;
    chk("m1_rst", mode_one_q, DMR_M1_RESET);
    chk("m2_rst", mode_two_q, DMR_M2_RESET);
    chk("dll_rst", dll_on, 1);
    chk("dm_rst", dm_on, 1);
    chk("drv_rst", drive_sel, DMR_DRV_RZQ7);
    for (int i = 0; i < 3; i++) begin
      last = {3'h0, m1(0, i[0] ? DMR_DRV_RZQ7 : DMR_DRV_RZQ6, i[1:0], 0, 0, i[0], i[1])};
      ctrl.mrs(DMR_BA_MODE_ONE, last[15:0]);
      chk("m1", mode_one_q, last);
      chk("al", additive_lat, i[1:0]);
      chk("drv", drive_sel, {last[5], last[1]});
      chk("tdqs", tdqs_on, i[0]);
      chk("dm", dm_on, !i[0]);
      chk("qoff", outputs_off, i[1]);
    end
    ctrl.mrs(DMR_BA_MODE_TWO, 16'h0468);
    chk("m2", mode_two_q, 19'h00468);
    chk("cwl", cas_write_lat, 3'h5);
    chk("asr", asr_on, 1);
    chk("rwr", rtt_wr_sel, 2'h2);
    chk("m1_hold", mode_one_q, last);
    ctrl.mrs(DMR_BA_MODE_TWO, 16'h0280);
    chk("srt", srt_on, 1);
    chk("asr_off", asr_on, 0);
    ctrl.mrs(3'h3, 16'hffff);
    chk("ba3_m1", mode_one_q, last);
    chk("ba3_m2", mode_two_q, 19'h00280);
    odt_pin = 1;
    for (int c = 1; c < 6; c++) begin
      ctrl.mrs(DMR_BA_MODE_ONE, m1(0, DMR_DRV_RZQ7, 0, c[2:0], 0, 0, 0));
      settle();
      chk("rtt", rtt_code, c[2:0]);
    end
    ctrl.mrs(DMR_BA_MODE_ONE, m1(0, DMR_DRV_RZQ7, 0, DMR_RTT_DIV4, 0, 0, 0));
    write_burst = 1;
    settle();
    chk("wr_used", rtt_wr_used, 1);
    write_burst = 0;
    odt_pin = 0;
    settle();
    chk("wr_back", rtt_wr_used, 0);
    chk("odt_off", rtt_code, DMR_RTT_OFF);
    read_burst = 1;
    settle();
    chk("rd_rtt", rtt_code, DMR_RTT_OFF);
    chk("rd_wr", rtt_wr_used, 0);
    read_burst = 0;
    odt_pin = 1;
    for (int q = 0; q < 2; q++) begin
      ctrl.mrs(DMR_BA_MODE_ONE, m1(0, DMR_DRV_RZQ7, 0, DMR_RTT_DIV12, 1, 0, q[0]));
      settle();
      chk("wlev", wlev_on, 1);
      chk("wl_bad", wlev_rtt_bad, !q[0]);
      chk("wl_rtt", rtt_code, q[0] ? DMR_RTT_DIV12 : DMR_RTT_OFF);
    end
    odt_pin = 0;
    ctrl.mrs(DMR_BA_MODE_ONE, m1(0, DMR_DRV_RZQ7, 0, 0, 0, 0, 0));
    sr_cycle();
    chk("dll_rst_p", pulse, 1);
    chk("dll_back", dll_on, 1);
    ctrl.mrs(DMR_BA_MODE_ONE, m1(1, DMR_DRV_RZQ7, 0, 0, 0, 0, 0));
    settle();
    chk("dll_off", dll_on, 0);
    sr_cycle();
    chk("dll_parked", dll_on, 0);
    chk("no_pulse", pulse, 0);
    x8_part = 0;
    ctrl.mrs(DMR_BA_MODE_ONE, m1(0, DMR_DRV_RZQ7, 0, 0, 0, 1, 0));
    chk("x4_td_bit", mode_one_q[DMR_M1_TDQS], 0);
    chk("x4_tdqs", tdqs_on, 0);
    chk("x4_dm", dm_on, 1);
    reset_n = 0;
    @(negedge clock);
    chk("m1_clr", mode_one_q, DMR_M1_RESET);
    chk("dll_clr", dll_on, 1);
    chk("drv_clr", drive_sel, DMR_DRV_RZQ7);
    reset_n = 1;
    ctrl.mrs(DMR_BA_MODE_TWO, 16'h0018);
    chk("m2_after", mode_two_q, 19'h00018);
    chk("cwl_after", cas_write_lat, 3'h3);
    chk("m1_after", mode_one_q, DMR_M1_RESET);
    summarize();
  end
endmodule // dmr_mode_regs_tb
